// file: pkg/fcs_pkg.sv
// fcs_pkg: constants for the function command and status register pair
// assumes: configuration dword at 04h holds command (low half) and status (high half)
package fcs_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] FCS_CMD_OFFSET = 8'h04; // command word byte offset
  localparam logic [7:0] FCS_STS_OFFSET = 8'h06; // status word byte offset
  localparam logic [7:0] FCS_DWORD_MASK = 8'hFC; // dword select mask
  localparam logic [15:0] FCS_CMD_RESET = 16'h0000; // command reset value
  localparam logic [15:0] FCS_STS_RESET = 16'h0230; // status reset value
  // ****************************************
  // command field positions
  // ****************************************
  localparam int FCS_CMD_INT_INHIBIT = 10; // interrupt inhibit
  localparam int FCS_CMD_SERR_EN = 8; // system_error_drive_permit
  localparam int FCS_CMD_PERR_EN = 6; // parity_response_permit
  localparam int FCS_CMD_MWI_EN = 4; // write_invalidate_permit
  localparam int FCS_CMD_MASTER_EN = 2; // initiator_permit
  localparam int FCS_CMD_MEM_EN = 1; // memory_space_permit
  // ****************************************
  // status field positions
  // ****************************************
  localparam int FCS_STS_PAR = 15; // parity_fault_seen
  localparam int FCS_STS_SYS = 14; // system_fault_signalled
  localparam int FCS_STS_INITIATOR_ABORT_RECEIVED = 13; // initiator_abort_received
  localparam int FCS_STS_TABORT_RX = 12; // target_abort_received
  localparam int FCS_STS_TABORT_TX = 11; // target_abort_signalled
  localparam logic [1:0] FCS_SELECT_TIMING = 2'h1; // select_timing_code, medium
  localparam int FCS_STS_DPAR_M = 8; // data_parity_fault_as_master
  localparam int FCS_STS_FAST_CLK = 5; // fast_clock_capable
  localparam int FCS_STS_CAP_LIST = 4; // capability_chain_present
  localparam int FCS_STS_INT = 3; // pending interrupt mirror
  // ****************************************
  // master write command codes
  // ****************************************
  localparam logic [3:0] FCS_CODE_MEM_WRITE = 4'h7; // plain memory write
  localparam logic [3:0] FCS_CODE_MWI = 4'hF; // memory write and invalidate
  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic int_inhibit;
    logic serr_en;
    logic perr_en;
    logic mwi_en;
    logic master_en;
    logic mem_en;
    logic par_seen;
    logic sys_sig;
    logic initiator_abort_received_rx;
    logic tabort_rx;
    logic tabort_tx;
    logic dpar_m;
    logic serr_out;
    logic perr_out;
    logic [31:0] rdata;
  } fcs_state_s;
endpackage

// file: verilog/fcs_regs.sv
// fcs_regs: command and status registers of the host controller function
// assumes: configuration cycles arrive pre-decoded, one cycle per access, on clock
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - command word at 04h, resets to zero
// - command bits 15..11 read zero
// - bit 10 one blocks interrupt output
// - fast back-to-back bit 9 reads zero
// - bit 8 gates system error on address parity
// - stepping bit 7 hardwired zero
// - bit 6 gates parity error output
// - palette snoop bit 5 reads zero
// - bit 4 selects write-invalidate command
// - special cycles ignored, bit 3 zero
// - bit 2 gates initiating bus cycles
// - bit 1 gates memory response
// - io space bit 0 reads zero
// - status word at 06h, resets 0230h
// - bit 15 latches address or data parity error
// - bit 14 latches signalled system error
// - bit 13 latches received master abort
// - bit 12 latches received target abort
// - bit 11 latches signalled target abort
// - bits 10..9 fixed at 01b
// - bit 8 latches master data parity error
// - bit 3 mirrors pending interrupt
// - bits 5 and 4 hardwired one
module fcs_regs
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // bus events from the function's bus logic
  input wire logic addr_parity_err,
  input wire logic data_parity_err,
  input wire logic bus_parity_fault_seen,
  input wire logic master_active,
  input wire logic master_abort,
  input wire logic target_abort_in,
  input wire logic target_abort_out,
  // interrupt and initiator requests from the core
  input wire logic func_irq,
  input wire logic core_bus_req,
  input wire logic mem_decode_hit,
  // gated controls to the bus logic
  output logic irq_out,
  output logic bus_req,
  output logic mem_claim,
  output logic [3:0] write_cmd_code,
  output logic system_fault_output,
  output logic parity_fault_output,
  output logic initiator_permit,
  output logic memory_space_permit
);
  import fcs_pkg::*;

  // ****************************************
  // state and decode
  // ****************************************
  fcs_state_s st_r; // registered state
  fcs_state_s st_nxt; // next state
  logic hit; // access targets the command/status dword
  logic [15:0] cmd_view; // command as read
  logic [15:0] sts_view; // status as read
  logic [15:0] clr_mask; // write-one-to-clear mask for status
  logic serr_fire; // system error raised this cycle
  logic perr_fire; // parity error output raised this cycle

  // low address bits pick a byte lane, not a register
  assign hit = (cfg_addr & FCS_DWORD_MASK) == FCS_CMD_OFFSET;

  // command view: only writable bits come from storage, the rest read zero
  always_comb
  begin
    cmd_view = FCS_CMD_RESET;
    cmd_view[FCS_CMD_INT_INHIBIT] = st_r.int_inhibit;
    cmd_view[FCS_CMD_SERR_EN] = st_r.serr_en;
    cmd_view[FCS_CMD_PERR_EN] = st_r.perr_en;
    cmd_view[FCS_CMD_MWI_EN] = st_r.mwi_en;
    cmd_view[FCS_CMD_MASTER_EN] = st_r.master_en;
    cmd_view[FCS_CMD_MEM_EN] = st_r.mem_en;
  end

  // status view: sticky bits plus fixed fields and the live interrupt
  always_comb
  begin
    sts_view = FCS_STS_RESET;
    sts_view[FCS_STS_PAR] = st_r.par_seen;
    sts_view[FCS_STS_SYS] = st_r.sys_sig;
    sts_view[FCS_STS_INITIATOR_ABORT_RECEIVED] = st_r.initiator_abort_received_rx;
    sts_view[FCS_STS_TABORT_RX] = st_r.tabort_rx;
    sts_view[FCS_STS_TABORT_TX] = st_r.tabort_tx;
    sts_view[FCS_STS_DPAR_M] = st_r.dpar_m;
    sts_view[FCS_STS_INT] = func_irq;
  end

  // clear mask built from the status byte lanes of a write
  always_comb
  begin
    clr_mask = 16'h0000;
    if (cfg_wr && hit)
    begin
      if (cfg_be[2])
        clr_mask[7:0] = cfg_wdata[23:16];
      if (cfg_be[3])
        clr_mask[15:8] = cfg_wdata[31:24];
    end
  end

  // error outputs only fire when their permit is set
  assign serr_fire = addr_parity_err && st_r.serr_en;
  assign perr_fire = data_parity_err && st_r.perr_en;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    // command writes touch only the writable bits
    if (cfg_wr && hit && cfg_be[1])
    begin
      st_nxt.int_inhibit = cfg_wdata[FCS_CMD_INT_INHIBIT];
      st_nxt.serr_en = cfg_wdata[FCS_CMD_SERR_EN];
    end
    if (cfg_wr && hit && cfg_be[0])
    begin
      st_nxt.perr_en = cfg_wdata[FCS_CMD_PERR_EN];
      st_nxt.mwi_en = cfg_wdata[FCS_CMD_MWI_EN];
      st_nxt.master_en = cfg_wdata[FCS_CMD_MASTER_EN];
      st_nxt.mem_en = cfg_wdata[FCS_CMD_MEM_EN];
    end
    // sticky status: clear first, then a same-cycle event sets it again
    if (clr_mask[FCS_STS_PAR]) st_nxt.par_seen = 1'b0;
    if (clr_mask[FCS_STS_SYS]) st_nxt.sys_sig = 1'b0;
    if (clr_mask[FCS_STS_INITIATOR_ABORT_RECEIVED]) st_nxt.initiator_abort_received_rx = 1'b0;
    if (clr_mask[FCS_STS_TABORT_RX]) st_nxt.tabort_rx = 1'b0;
    if (clr_mask[FCS_STS_TABORT_TX]) st_nxt.tabort_tx = 1'b0;
    if (clr_mask[FCS_STS_DPAR_M]) st_nxt.dpar_m = 1'b0;
    if (addr_parity_err || data_parity_err)
      st_nxt.par_seen = 1'b1;
    if (serr_fire)
      st_nxt.sys_sig = 1'b1;
    if (master_abort)
      st_nxt.initiator_abort_received_rx = 1'b1;
    if (target_abort_in)
      st_nxt.tabort_rx = 1'b1;
    if (target_abort_out)
      st_nxt.tabort_tx = 1'b1;
    if (bus_parity_fault_seen && master_active && st_r.perr_en)
      st_nxt.dpar_m = 1'b1;
    // registered one-cycle error pulses
    st_nxt.serr_out = serr_fire;
    st_nxt.perr_out = perr_fire;
    // read data: combined dword, zero for other offsets
    if (cfg_rd)
    begin
      if (hit)
        st_nxt.rdata = {sts_view, cmd_view};
      else
        st_nxt.rdata = 32'h0000_0000;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // read data straight from its register
  assign cfg_rdata = st_r.rdata;
  // gates driven combinationally from the stored command bits
  assign irq_out = func_irq && !st_r.int_inhibit;
  assign bus_req = core_bus_req && st_r.master_en;
  assign mem_claim = mem_decode_hit && st_r.mem_en;
  assign write_cmd_code = st_r.mwi_en ? FCS_CODE_MWI : FCS_CODE_MEM_WRITE;
  // one-cycle error pulses and permit mirrors, all from flip-flops
  assign system_fault_output = st_r.serr_out;
  assign parity_fault_output = st_r.perr_out;
  assign initiator_permit = st_r.master_en;
  assign memory_space_permit = st_r.mem_en;

  // ****************************************
  // assertions
  // ****************************************
  // all checks run on the rising edge and rest while reset is held
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  irq_gate_a: assert property (st_r.int_inhibit |-> !irq_out)
    else $error("interrupt asserted while inhibited");
  serr_gate_a: assert property (system_fault_output |-> $past(addr_parity_err) && $past(st_r.serr_en))
    else $error("system error without enabled cause");
  perr_gate_a: assert property (data_parity_err && st_r.perr_en |=> parity_fault_output)
    else $error("parity error output missing");
  master_gate_a: assert property (bus_req |-> initiator_permit)
    else $error("bus request without initiator permit");
  mem_gate_a: assert property (!st_r.mem_en |-> !mem_claim)
    else $error("memory claim while disabled");
  cmd_fixed_a: assert property (cfg_rd && hit |=> cfg_rdata[15:11] == 5'h00 && cfg_rdata[9] == 1'b0
      && cfg_rdata[7] == 1'b0 && cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0 && cfg_rdata[0] == 1'b0)
    else $error("fixed command bits not zero");
  sts_fixed_a: assert property (cfg_rd && hit |=> cfg_rdata[26:25] == FCS_SELECT_TIMING
      && cfg_rdata[21:20] == 2'h3)
    else $error("fixed status bits wrong");
  par_sticky_a: assert property (addr_parity_err || data_parity_err |=> st_r.par_seen [*2]
      or (st_r.par_seen ##1 !st_r.par_seen))
    else $error("parity seen not latched");
  sys_set_a: assert property (serr_fire |=> st_r.sys_sig)
    else $error("signalled system error not latched");
  abort_set_a: assert property (master_abort |=> st_r.initiator_abort_received_rx)
    else $error("master abort not latched");
  w1c_hold_a: assert property (st_r.tabort_tx && !target_abort_out && !clr_mask[FCS_STS_TABORT_TX]
      |=> st_r.tabort_tx)
    else $error("sticky bit lost without clear");
  w1c_clear_a: assert property (clr_mask[FCS_STS_INITIATOR_ABORT_RECEIVED] && !master_abort |=> !st_r.initiator_abort_received_rx)
    else $error("write one did not clear");
  // ****************************************
  // reset and read-back checks
  // ****************************************
  // the first edge after reset must see every stored bit cleared
  reset_clear_a: assert property ($rose(rst_n) |-> st_r == '0)
    else $error("state not cleared by reset");
  // the interrupt mirror in a read is the pending level at the read edge
  irq_mirror_a: assert property (cfg_rd && hit |=> cfg_rdata[16 + FCS_STS_INT] == $past(func_irq))
    else $error("status interrupt bit does not mirror pending level");
  // offsets outside the command/status dword read as zero
  unmapped_zero_a: assert property (cfg_rd && !hit |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped offset returned data");
  // ****************************************
  // sticky status checks
  // ****************************************
  // an event landing with its own write-one clear still leaves the bit set
  par_set_wins_a: assert property ((addr_parity_err || data_parity_err) && clr_mask[FCS_STS_PAR]
      |=> st_r.par_seen)
    else $error("parity clear beat a same-cycle event");
  // a received target abort is latched on the next edge
  tabort_rx_set_a: assert property (target_abort_in |=> st_r.tabort_rx)
    else $error("received target abort not latched");
  // a signalled target abort is latched on the next edge
  tabort_tx_set_a: assert property (target_abort_out |=> st_r.tabort_tx)
    else $error("signalled target abort not latched");
  // master data parity needs the bus line, mastership and the parity permit
  dpar_set_a: assert property (bus_parity_fault_seen && master_active && st_r.perr_en |=> st_r.dpar_m)
    else $error("master data parity error not latched");
  dpar_quiet_a: assert property (!st_r.dpar_m && !(bus_parity_fault_seen && master_active && st_r.perr_en)
      |=> !st_r.dpar_m)
    else $error("master data parity bit set without cause");
  // the system error bit only rises on a permitted system error
  sys_quiet_a: assert property (!st_r.sys_sig && !serr_fire |=> !st_r.sys_sig)
    else $error("system error bit set without cause");
  // ****************************************
  // command gate checks
  // ****************************************
  // a pending interrupt passes whenever it is not inhibited
  irq_pass_a: assert property (func_irq && !st_r.int_inhibit |-> irq_out)
    else $error("pending interrupt blocked while not inhibited");
  // a low-lane write sets the write command code from its invalidate bit
  mwi_code_a: assert property (cfg_wr && hit && cfg_be[0]
      |=> write_cmd_code == ($past(cfg_wdata[FCS_CMD_MWI_EN]) ? FCS_CODE_MWI : FCS_CODE_MEM_WRITE))
    else $error("write command code does not follow invalidate permit");
  // a low-lane write sets the memory permit from its bit
  mem_write_a: assert property (cfg_wr && hit && cfg_be[0]
      |=> memory_space_permit == $past(cfg_wdata[FCS_CMD_MEM_EN]))
    else $error("memory permit does not follow write");
  // no parity error output without a permitted data parity error
  perr_cause_a: assert property (parity_fault_output |-> $past(data_parity_err) && $past(st_r.perr_en))
    else $error("parity error output without enabled cause");

  // ****************************************
  // cover points
  // ****************************************
  // inhibited interrupt, clear race, system error, read, master parity
  inhibit_cov_a: cover property (func_irq && st_r.int_inhibit);
  dpar_cov_a: cover property (bus_parity_fault_seen && master_active && st_r.perr_en);
  clear_race_cov_a: cover property (clr_mask[FCS_STS_PAR] && data_parity_err);
  serr_cov_a: cover property (system_fault_output);
  read_cov_a: cover property (cfg_rd && hit ##1 cfg_rdata[1]);
endmodule
`default_nettype wire

// file: tb/fcs_bus_agent.sv
// fcs_bus_agent: other agents on the parallel bus, raising event lines
// assumes: fire_req changes by non-blocking assignment at the falling edge
`timescale 1ns/1ns
`default_nettype none
module fcs_bus_agent
(
  // clock
  input wire logic clock,
  // events the bench asks for
  input wire logic [6:0] fire_req,
  // event lines to the function
  output logic [6:0] ev_r
);
  // ****************************************
  // event launch
  // ****************************************
  // each event stands one whole cycle, launched away from the sampling edge
  always @(negedge clock)
  begin
    ev_r <= fire_req;
  end
endmodule
`default_nettype wire

// file: tb/fcs_regs_tb.sv
// fcs_regs_tb: self-checking bench of the command and status registers
// assumes: fcs_pkg compiled first, fcs_regs and fcs_bus_agent present
`timescale 1ns/1ns
`default_nettype none
module fcs_regs_tb;
  import fcs_pkg::*;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic [6:0] fire = 7'h00;
  logic [6:0] ev;
  logic func_irq = 1'b1;
  logic core_bus_req = 1'b1;
  logic mem_decode_hit = 1'b1;
  logic irq_out, bus_req, mem_claim, sfo, pfo, ip, mp;
  logic [3:0] wcode;
  int err_total = 0;
  int checked = 0;
  // 20 MHz clock
  always #25 clock = ~clock;
  fcs_bus_agent agent (.clock(clock), .fire_req(fire), .ev_r(ev));
  fcs_regs dut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .addr_parity_err(ev[6]),
    .data_parity_err(ev[5]), .bus_parity_fault_seen(ev[4]), .master_active(ev[3]), .master_abort(ev[2]),
    .target_abort_in(ev[1]), .target_abort_out(ev[0]), .func_irq(func_irq), .core_bus_req(core_bus_req),
    .mem_decode_hit(mem_decode_hit), .irq_out(irq_out), .bus_req(bus_req), .mem_claim(mem_claim),
    .write_cmd_code(wcode), .system_fault_output(sfo), .parity_fault_output(pfo),
    .initiator_permit(ip), .memory_space_permit(mp));
  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle configuration write
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask
  // read returns data the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clock);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clock);
    cfg_rd = 1'b0;
    chk("cfg_rdata", cfg_rdata, exp);
  endtask
  // events stand one cycle; returns when the resulting pulse is visible
  task automatic fire_ev(input logic [6:0] v);
    @(negedge clock);
    fire <= v;
    @(negedge clock);
    fire <= 7'h00;
    @(negedge clock);
  endtask
  // gated controls in one compare: irq, req, claim, code, permits
  task automatic outs(input logic [31:0] exp);
    chk("controls", {23'h0, irq_out, bus_req, mem_claim, wcode, ip, mp}, exp);
  endtask
  // verdict
  task automatic results;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h04, 32'h0238_0000);
    outs({23'h0, 3'b100, FCS_CODE_MEM_WRITE, 2'b00});
    rd(8'h08, 32'h0);
    // all ones: only writable command bits take, fixed status bits hold
    wr(8'h06, 4'hF, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0238_0556);
    outs({23'h0, 3'b011, FCS_CODE_MWI, 2'b11});
    fire_ev(7'h40);
    chk("sys_pulse", 32'(sfo), 32'h1);
    @(negedge clock);
    chk("sys_pulse_end", 32'(sfo), 32'h0);
    fire_ev(7'h3F);
    chk("par_pulse", 32'(pfo), 32'h1);
    rd(8'h04, 32'hFB38_0556);
    wr(8'h04, 4'hC, 32'h0000_0000);
    rd(8'h04, 32'hFB38_0556);
    wr(8'h04, 4'hC, 32'hFFFF_0000);
    rd(8'h04, 32'h0238_0556);
    // command cleared: gates close, interrupt passes
    wr(8'h04, 4'h3, 32'h0);
    rd(8'h04, 32'h0238_0000);
    outs({23'h0, 3'b100, FCS_CODE_MEM_WRITE, 2'b00});
    fire_ev(7'h78);
    chk("pulses_off", {30'h0, sfo, pfo}, 32'h0);
    rd(8'h04, 32'h8238_0000);
    // low byte lane only
    wr(8'h04, 4'h1, 32'hFFFF_FFFF);
    func_irq = 1'b0;
    rd(8'h04, 32'h8230_0056);
    outs({23'h0, 3'b011, FCS_CODE_MWI, 2'b11});
    // mid-run reset: command and sticky status return to their reset values
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h04, 32'h0230_0000);
    outs({23'h0, 3'b000, FCS_CODE_MEM_WRITE, 2'b00});
    results;
  end
  // watchdog: the sequence needs well under 200 cycles
  initial
  begin
    #200000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
